// [verilog/dsgcr_top.sv]
// global control register bank of the deserializer hub
//
// How it works
// - address field shows the address in use
// - override clear: field read-only, shows strap
// - override set: written address becomes active
// - reload bit restarts rom load, self-clears
// - software polls init-done after a reload
// - full soft reset returns address and config to reset values, reloads rom, self-clears
// - logic soft reset keeps config, self-clears
// - controller enable bit gates local controller
// - mode 0: unlocked transmit port goes high-z
// - mode 1: unlocked port keeps control, LP-11 with sleep select 1 and enable 1
// - sleep select 1, enable 0: outputs high-z
// - sleep select 0, mode 1, no lock: outputs HS-0
// - parity enable bit gates receiver parity checker
// - force bit makes reference clock appear present
// - status bit 6 set when load finishes
`timescale 1ns/1ps
`default_nettype none
module dsgcr_top
  import dsgcr_pkg::*;
#(
  parameter int NUM_RX   = 4,
  parameter int NUM_TX   = 2,
  parameter int LOAD_CYC = ROM_LOAD_CYC,
  parameter int HOLD_CYC = RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,

  // register access from the serial control bus target
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,

  // pins: address straps and reference clock detector
  input  wire logic [6:0]        addr_strap,
  input  wire logic              reference_clock_input_detect,

  // receiver lock and port assignment, same clock
  input  wire logic [NUM_RX-1:0] rx_lock,
  input  wire logic [NUM_RX-1:0] tx_rx_assign [NUM_TX],

  // configuration outputs
  output logic      [6:0]        bus_address,
  output logic                   controller_en,
  output logic                   parity_check_en,
  output logic                   reference_clock_input_present,
  output dsgcr_tx_e              tx_state [NUM_TX],

  // reset and load status
  output logic                   logic_reset,
  output logic                   rom_load_active,
  output logic                   init_done
);

  // all state of this module except the transmit states
  typedef struct packed {
    logic [6:0]  addr_field;   // software address
    logic        ovr;          // address override select
    logic [2:0]  pend;         // pending reset and reload bits
    logic [5:0]  cfg;          // general configuration
    logic [6:0]  strap;        // captured strap address
    logic        strap_taken;  // strap capture done
    logic [7:0]  rdata;        // read data
    logic        rvalid;       // read answer strobe
    logic        ctrl_en;      // registered config outputs
    logic        par_en;
    logic        ref_ok;
    logic [6:0]  addr_out;
  } dsgcr_top_s;

  dsgcr_top_s st_r;
  dsgcr_top_s st_nxt;

  // transmit states are kept apart from the struct
  dsgcr_tx_e tx_r   [NUM_TX];
  dsgcr_tx_e tx_nxt [NUM_TX];

  // synchronised pin levels
  logic [7:0] pins_sync;
  logic [6:0] strap_s;     // strap after two flops
  logic       refdet_s;    // detector after two flops

  // decode strobes
  logic wr_addr;
  logic wr_rst;
  logic wr_cfg;

  // active address and read mux
  logic [6:0] active_addr;
  logic [7:0] rd_mux;

  // link to the sequencer
  dsgcr_seq_if sq_if ();

  // straps and detector come from outside the clock domain
  dsgcr_sync #(
    .W (8)
  ) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({reference_clock_input_detect, addr_strap}),
    .sync_out (pins_sync)
  );

  assign strap_s  = pins_sync[6:0];
  assign refdet_s = pins_sync[7];

  // reset and rom reload sequencing
  dsgcr_seq #(
    .LOAD_CYC (LOAD_CYC),
    .HOLD_CYC (HOLD_CYC)
  ) u_seq (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .sq              (sq_if.seq),
    .logic_reset     (logic_reset),
    .rom_load_active (rom_load_active)
  );

  // pending bits are the requests; they hold until taken or cleared by a full soft reset
  assign sq_if.logic_req  = st_r.pend[RST_LOGIC_BIT];
  assign sq_if.full_req   = st_r.pend[RST_FULL_BIT];
  assign sq_if.reload_req = st_r.pend[RST_RELOAD_BIT];
  assign init_done        = sq_if.init_done;

  // write decode
  assign wr_addr = reg_wr && (reg_addr == ADDR_BUS_TARGET);
  assign wr_rst  = reg_wr && (reg_addr == ADDR_SOFT_RST);
  assign wr_cfg  = reg_wr && (reg_addr == ADDR_GEN_CFG);

  // the field always shows the address in use
  assign active_addr = st_r.ovr ? st_r.addr_field : st_r.strap;

  // read mux; reserved bits and unmapped offsets give zero
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_BUS_TARGET: begin
        rd_mux[ADDR_MSB:ADDR_LSB] = active_addr;
        rd_mux[OVR_BIT]           = st_r.ovr;
      end
      ADDR_SOFT_RST: begin
        rd_mux[2:0] = st_r.pend;
      end
      ADDR_GEN_CFG: begin
        rd_mux[5:0] = st_r.cfg;
      end
      ADDR_DEV_STATUS: begin
        rd_mux[STS_INIT_DONE_BIT] = sq_if.init_done;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // transmit output state per port
  generate
    for (genvar t = 0; t < NUM_TX; t++) begin : g_tx
      logic any_lock;
      assign any_lock = |(tx_rx_assign[t] & rx_lock);
      always_comb begin
        if (st_r.cfg[CFG_SLEEP_SEL_BIT] && !st_r.cfg[CFG_OE_BIT]) begin
          tx_nxt[t] = TX_HIZ;
        end else if (any_lock) begin
          tx_nxt[t] = TX_NORMAL;
        end else if (!st_r.cfg[CFG_OE_MODE_BIT]) begin
          tx_nxt[t] = TX_HIZ;
        end else if (!st_r.cfg[CFG_SLEEP_SEL_BIT]) begin
          tx_nxt[t] = TX_HS0;
        end else begin
          tx_nxt[t] = TX_LP11;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          tx_r[t] <= TX_HIZ;
        end else begin
          tx_r[t] <= tx_nxt[t];
        end
      end
      assign tx_state[t] = tx_r[t];
    end
  endgenerate

  // next state of the register bank
  always_comb begin
    st_nxt = st_r;

    // strap follows the synced pins until the power-up load ends, then freezes;
    // srst clears the synchroniser, so a grab right after release would read zero
    if (!st_r.strap_taken) begin
      st_nxt.strap = strap_s;
      if (sq_if.init_done) begin
        st_nxt.strap_taken = 1'b1;
      end
    end

    // address register; field accepted only with override set
    if (wr_addr) begin
      st_nxt.ovr = reg_wdata[OVR_BIT];
      if (reg_wdata[OVR_BIT]) begin
        st_nxt.addr_field = reg_wdata[ADDR_MSB:ADDR_LSB];
      end
    end

    // taken requests drop first, so a new write wins
    if (sq_if.ack) begin
      st_nxt.pend = 3'h0;
    end
    if (wr_rst) begin
      // write one to set, zeros leave bits alone
      st_nxt.pend = st_nxt.pend | reg_wdata[2:0];
    end

    // general configuration
    if (wr_cfg) begin
      st_nxt.cfg = reg_wdata[5:0];
    end

    // full soft reset returns configuration to reset values
    if (sq_if.cfg_clear) begin
      st_nxt.addr_field = BUS_ADDR_RST;
      st_nxt.ovr        = 1'b0;
      st_nxt.cfg        = GEN_CFG_RST;
      st_nxt.pend       = 3'h0;
    end

    // registered outputs follow the configuration
    st_nxt.ctrl_en  = st_r.cfg[CFG_CTRL_EN_BIT];
    st_nxt.par_en   = st_r.cfg[CFG_PARITY_BIT];
    st_nxt.ref_ok   = st_r.cfg[CFG_FORCE_REF_BIT] | refdet_s;
    st_nxt.addr_out = active_addr;

    // read answer one cycle after the strobe
    st_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      st_nxt.rdata = rd_mux;
    end
  end

  // register the bank; srst gives documented reset values
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r.addr_field  <= BUS_ADDR_RST;
      st_r.ovr         <= 1'b0;
      st_r.pend        <= 3'h0;
      st_r.cfg         <= GEN_CFG_RST;
      st_r.strap       <= 7'h00;
      st_r.strap_taken <= 1'b0;
      st_r.rdata       <= 8'h00;
      st_r.rvalid      <= 1'b0;
      st_r.ctrl_en     <= 1'b0;
      st_r.par_en      <= 1'b1;
      st_r.ref_ok      <= 1'b0;
      st_r.addr_out    <= 7'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign reg_rdata       = st_r.rdata;
  assign reg_rvalid      = st_r.rvalid;
  assign bus_address     = st_r.addr_out;
  assign controller_en   = st_r.ctrl_en;
  assign parity_check_en = st_r.par_en;
  assign reference_clock_input_present  = st_r.ref_ok;

endmodule : dsgcr_top
`default_nettype wire

// [verilog/dsgcr_pkg.sv]
// constants and types shared by the global control register bank
package dsgcr_pkg;
  // register offsets on the serial control bus
  localparam logic [7:0] ADDR_BUS_TARGET = 8'h00;
  localparam logic [7:0] ADDR_SOFT_RST   = 8'h01;
  localparam logic [7:0] ADDR_GEN_CFG    = 8'h02;
  localparam logic [7:0] ADDR_DEV_STATUS = 8'h04;
  // bus_target_address fields
  localparam int OVR_BIT  = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  // soft_reset_control fields
  localparam int RST_LOGIC_BIT  = 0;
  localparam int RST_FULL_BIT   = 1;
  localparam int RST_RELOAD_BIT = 2;
  // general_configuration fields
  localparam int CFG_FORCE_REF_BIT = 0;
  localparam int CFG_PARITY_BIT    = 1;
  localparam int CFG_SLEEP_SEL_BIT = 2;
  localparam int CFG_OE_BIT        = 3;
  localparam int CFG_OE_MODE_BIT   = 4;
  localparam int CFG_CTRL_EN_BIT   = 5;
  // device_status_register field
  localparam int STS_INIT_DONE_BIT = 6;
  // reset values
  localparam logic [6:0] BUS_ADDR_RST = 7'h00;
  localparam logic [5:0] GEN_CFG_RST  = 6'h1E;
  // timing: clock period and times in ns, counts derived (rounded up)
  localparam int CLK_PERIOD_NS = 100;
  localparam int ROM_LOAD_NS   = 2000;
  localparam int RST_HOLD_NS   = 500;
  localparam int ROM_LOAD_CYC  = (ROM_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  // transmit output state per camera-serial port
  typedef enum logic [1:0] {
    TX_NORMAL = 2'b00,
    TX_HIZ    = 2'b01,
    TX_LP11   = 2'b10,
    TX_HS0    = 2'b11
  } dsgcr_tx_e;
  // reset and reload sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_LOAD  = 2'b01,
    SEQ_LRST  = 2'b10,
    SEQ_FRST  = 2'b11
  } dsgcr_seq_e;
endpackage : dsgcr_pkg

// [verilog/dsgcr_seq_if.sv]
// request and status bundle between register bank and sequencer
`timescale 1ns/1ps
`default_nettype none
interface dsgcr_seq_if;
  logic reload_req;  // rom reload pending
  logic full_req;    // full soft reset pending
  logic logic_req;   // logic-only soft reset pending
  logic ack;         // sequencer takes pending requests
  logic cfg_clear;   // return configuration registers to reset values
  logic init_done;   // configuration load finished
  modport regs (output reload_req, full_req, logic_req,
                input ack, cfg_clear, init_done);
  modport seq  (input reload_req, full_req, logic_req,
                output ack, cfg_clear, init_done);
endinterface : dsgcr_seq_if
`default_nettype wire

// [verilog/dsgcr_sync.sv]
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module dsgcr_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // first stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dsgcr_sync_s;

  dsgcr_sync_s st_r;
  dsgcr_sync_s st_nxt;

  // shift one stage per edge
  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule : dsgcr_sync
`default_nettype wire

// [verilog/dsgcr_seq.sv]
// soft reset and rom reload sequencer
`timescale 1ns/1ps
`default_nettype none
module dsgcr_seq
  import dsgcr_pkg::*;
#(
  parameter int LOAD_CYC = ROM_LOAD_CYC,
  parameter int HOLD_CYC = RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   srst,
  // requests from the register bank
  dsgcr_seq_if.seq    sq,
  // device-wide effects
  output logic        logic_reset,
  output logic        rom_load_active
);
  typedef struct packed {
    dsgcr_seq_e       state;
    logic [CNT_W-1:0] cnt;
    logic             init_done;
  } dsgcr_seq_s;

  localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

  dsgcr_seq_s st_r;
  dsgcr_seq_s st_nxt;

  // requests are only taken when idle; they stay pending during a load or logic reset, while cfg_clear drops them
  assign sq.ack = (st_r.state == SEQ_IDLE) &&
                  (sq.full_req || sq.logic_req || sq.reload_req);

  // next state: full reset beats logic reset beats reload
  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      SEQ_IDLE: begin
        if (sq.full_req) begin
          st_nxt.state = SEQ_FRST;
          st_nxt.cnt   = HOLD_LAST;
        end else if (sq.logic_req) begin
          st_nxt.state = SEQ_LRST;
          st_nxt.cnt   = HOLD_LAST;
        end else if (sq.reload_req) begin
          st_nxt.state     = SEQ_LOAD;
          st_nxt.cnt       = LOAD_LAST;
          st_nxt.init_done = 1'b0;
        end
      end
      SEQ_FRST: begin
        if (st_r.cnt == '0) begin
          // a full reset ends in a fresh configuration load
          st_nxt.state     = SEQ_LOAD;
          st_nxt.cnt       = LOAD_LAST;
          st_nxt.init_done = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      SEQ_LRST: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = SEQ_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      SEQ_LOAD: begin
        if (st_r.cnt == '0) begin
          st_nxt.state     = SEQ_IDLE;
          st_nxt.init_done = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      default: begin
        st_nxt.state = SEQ_IDLE;
      end
    endcase
  end

  // power-up starts with a load, flag low until it ends
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r.state     <= SEQ_LOAD;
      st_r.cnt       <= LOAD_LAST;
      st_r.init_done <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sq.init_done     = st_r.init_done;
  assign sq.cfg_clear     = (st_r.state == SEQ_FRST);
  assign logic_reset      = (st_r.state == SEQ_FRST) || (st_r.state == SEQ_LRST);
  assign rom_load_active  = (st_r.state == SEQ_LOAD);
endmodule : dsgcr_seq
`default_nettype wire

// [tb/dsgcr_sva.sv]
// assertion checker bound to the global control register bank
`timescale 1ns/1ps
`default_nettype none
module dsgcr_sva
  import dsgcr_pkg::*;
#(
  parameter int LOAD_CYC = ROM_LOAD_CYC,
  parameter int HOLD_CYC = RST_HOLD_CYC
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // configuration outputs and sequencer status
  input wire logic       controller_en,
  input wire logic       parity_check_en,
  input wire logic       reference_clock_input_present,
  input wire logic       logic_reset,
  input wire logic       rom_load_active,
  input wire logic       init_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // only reset writes that meet an idle sequencer and config writes outside a reset, so pending requests cannot blur timing
  logic cfg_wr;
  logic rst_wr;
  assign cfg_wr = reg_wr && reg_addr == ADDR_GEN_CFG && !logic_reset;
  assign rst_wr = reg_wr && reg_addr == ADDR_SOFT_RST && !logic_reset && !rom_load_active;
  // a written bit reaches its output two edges on unless a reset cut in
  property cfg_bit_p(b, o);
    cfg_wr |-> ##2 (logic_reset || o == $past(reg_wdata[b], 2));
  endproperty
  a_ctrl_en_follow: assert property (cfg_bit_p(CFG_CTRL_EN_BIT, controller_en))
    else $error("controller enable does not follow its bit");
  a_parity_follow: assert property (cfg_bit_p(CFG_PARITY_BIT, parity_check_en))
    else $error("parity enable does not follow its bit");
  a_reference_clock_input_forced: assert property (cfg_wr && reg_wdata[0] |-> ##2 (logic_reset || reference_clock_input_present))
    else $error("forced reference clock not shown present");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_DEV_STATUS |=> reg_rdata == 8'h00)
    else $error("unmapped offset reads nonzero");
  a_cfg_reserved: assert property (reg_rd && reg_addr == ADDR_GEN_CFG |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved config bits read nonzero");
  a_status_done: assert property (reg_rd && reg_addr == ADDR_DEV_STATUS |=> reg_rdata == {1'b0, $past(init_done), 6'h00})
    else $error("status read differs from init done");
  a_reload_run: assert property (rst_wr && reg_wdata == 8'h04 |-> ##2 (rom_load_active && !init_done) ##[1:40] (init_done && !rom_load_active))
    else $error("rom reload did not run and finish");
  a_logic_rst_len: assert property (rst_wr && reg_wdata == 8'h01 |-> ##2 logic_reset [*5] ##1 (!logic_reset && !rom_load_active))
    else $error("logic reset pulse has wrong length");
  a_full_rst_seq: assert property (rst_wr && reg_wdata[1] |-> ##2 logic_reset [*5] ##1 (rom_load_active && !controller_en && parity_check_en))
    else $error("full reset did not clear config and reload");
  // main scenarios
  c_reload: cover property (rst_wr && reg_wdata == 8'h04);
  c_full: cover property (rst_wr && reg_wdata[1]);
  c_override: cover property (reg_wr && reg_addr == ADDR_BUS_TARGET && reg_wdata[0]);
endmodule : dsgcr_sva
bind dsgcr_top dsgcr_sva #(.LOAD_CYC(LOAD_CYC), .HOLD_CYC(HOLD_CYC)) dsgcr_sva_i (
  .sys_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .controller_en,
  .parity_check_en, .reference_clock_input_present, .logic_reset, .rom_load_active, .init_done
);
`default_nettype wire

// [tb/dsgcr_host.sv]
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module dsgcr_host
  import dsgcr_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // answers from the bank
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  // requests
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe; data turned over after, so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // one-cycle read strobe, then wait a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    for (int n = 0; n < 3; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge sys_clk);
      #1;
    end
  endtask : rd
  // software waits for the load to end by polling the status flag
  task automatic poll(output logic [7:0] d);
    for (int n = 0; n < 60; n++) begin
      rd(ADDR_DEV_STATUS, d);
      if (d[STS_INIT_DONE_BIT] === 1'b1) break;
    end
  endtask : poll
endmodule : dsgcr_host
`default_nettype wire

// [tb/dsgcr_top_tb_top.sv]
// self-checking testbench of the global control register bank
`timescale 1ns/1ps
`default_nettype none
module dsgcr_top_tb_top;
  import dsgcr_pkg::*;
  logic            sys_clk;            // 10 MHz core clock
  logic            srst;               // synchronous reset
  logic      [7:0] reg_addr;           // host request lines
  logic            reg_wr;
  logic      [7:0] reg_wdata;
  logic            reg_rd;
  logic      [7:0] reg_rdata;          // bank answers
  logic            reg_rvalid;
  logic      [6:0] addr_strap;         // strap pins, held all run
  logic            reference_clock_input_detect;
  logic      [3:0] rx_lock;
  logic      [3:0] tx_rx_assign [2];
  logic      [6:0] bus_address;
  logic            controller_en;
  logic            parity_check_en;
  logic            reference_clock_input_present;
  dsgcr_tx_e       tx_state [2];
  logic            logic_reset;
  logic            rom_load_active;
  logic            init_done;
  integer          seed;               // fixed random seed
  int              failures = 0;
  int              cmp_count = 0;
  int              cycles = 0;         // hang guard
  logic      [7:0] d;                  // last read value
  logic      [6:0] a;                  // override address
  logic      [5:0] c;                  // config pattern
  dsgcr_top dsgcr_top_i (
    .sys_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
    .addr_strap, .reference_clock_input_detect, .rx_lock, .tx_rx_assign, .bus_address, .controller_en,
    .parity_check_en, .reference_clock_input_present, .tx_state, .logic_reset, .rom_load_active, .init_done
  );
  dsgcr_host host_i (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // expected transmit state; sleep-off with output disabled outranks lock
  function automatic dsgcr_tx_e exp_tx(logic [5:0] cf, logic lk);
    if (cf[CFG_SLEEP_SEL_BIT] && !cf[CFG_OE_BIT]) return TX_HIZ;
    if (lk) return TX_NORMAL;
    if (!cf[CFG_OE_MODE_BIT]) return TX_HIZ;
    return cf[CFG_SLEEP_SEL_BIT] ? TX_LP11 : TX_HS0;
  endfunction : exp_tx
  // single comparison point
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    seed = 32'h50da;
    srst = 1'b1;
    reference_clock_input_detect = 1'b0;
    rx_lock = 4'h0;
    tx_rx_assign[0] = 4'h3;
    tx_rx_assign[1] = 4'hC;
    addr_strap = 7'($random(seed));
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    host_i.poll(d);
    chk("status", d, 8'h40);
    host_i.rd(ADDR_BUS_TARGET, d);
    chk("addr", d, {addr_strap, 1'b0});
    host_i.rd(ADDR_SOFT_RST, d);
    chk("rst_ctl", d, 8'h00);
    host_i.rd(ADDR_GEN_CFG, d);
    chk("cfg", d, 8'h1E);
    // address field ignores writes until override is set in the same write
    a = ~addr_strap;
    host_i.wr(ADDR_BUS_TARGET, {a, 1'b0});
    host_i.rd(ADDR_BUS_TARGET, d);
    chk("addr", d, {addr_strap, 1'b0});
    host_i.wr(ADDR_BUS_TARGET, {a, 1'b1});
    host_i.rd(ADDR_BUS_TARGET, d);
    chk("addr", d, {a, 1'b1});
    chk("bus_address", 8'(bus_address), 8'(a));
    // reserved bits and an unmapped offset
    host_i.wr(ADDR_GEN_CFG, 8'hFF);
    host_i.rd(ADDR_GEN_CFG, d);
    chk("cfg", d, 8'h3F);
    host_i.rd(8'h07, d);
    chk("unmapped", d, 8'h00);
    // every mode/enable/sleep combination, unlocked first, then random locks
    for (int i = 0; i < 16; i++) begin
      c = 6'($random(seed));
      c[4:2] = 3'(i);
      host_i.wr(ADDR_GEN_CFG, {2'b00, c});
      rx_lock = (i < 8) ? 4'h0 : 4'($random(seed));
      reference_clock_input_detect = 1'($random(seed));
      repeat (4) @(posedge sys_clk);
      #1;
      for (int p = 0; p < 2; p++) begin
        chk("tx", 8'(tx_state[p]), 8'(exp_tx(c, |(rx_lock & tx_rx_assign[p]))));
      end
      chk("ctrl_en", 8'(controller_en), 8'(c[CFG_CTRL_EN_BIT]));
      chk("parity", 8'(parity_check_en), 8'(c[CFG_PARITY_BIT]));
      chk("reference_clock_input", 8'(reference_clock_input_present), 8'(c[0] | reference_clock_input_detect));
    end
    // logic-only reset keeps the programmed values
    host_i.wr(ADDR_SOFT_RST, 8'h01);
    repeat (8) @(posedge sys_clk);
    host_i.rd(ADDR_SOFT_RST, d);
    chk("rst_ctl", d, 8'h00);
    host_i.rd(ADDR_GEN_CFG, d);
    chk("cfg", d, {2'b00, c});
    // full reset returns config and address override to defaults
    host_i.wr(ADDR_SOFT_RST, 8'h02);
    repeat (8) @(posedge sys_clk);
    host_i.poll(d);
    host_i.rd(ADDR_GEN_CFG, d);
    chk("cfg", d, 8'h1E);
    host_i.rd(ADDR_BUS_TARGET, d);
    chk("addr", d, {addr_strap, 1'b0});
    // rom reload drops the done flag, then raises it again
    host_i.wr(ADDR_SOFT_RST, 8'h04);
    repeat (2) @(posedge sys_clk);
    host_i.rd(ADDR_DEV_STATUS, d);
    chk("status", d, 8'h00);
    host_i.poll(d);
    chk("status", d, 8'h40);
    wrap_up();
  end
endmodule : dsgcr_top_tb_top
`default_nettype wire
